// ==== hw/position_command_decoder_consts.vh ====
/*
 Constants of the position command decoder: opcodes, identifier fields,
 register offsets, reset values and result codes.
 Assumes it is included by bare name from the decoder and collector files.
*/
`ifndef POSITION_COMMAND_DECODER_CONSTS_VH
`define POSITION_COMMAND_DECODER_CONSTS_VH
`define OPC_MOVE_ABS 8'h8b
`define APP_PREFIX 8'h80
`define ID_MASTER_REQ 6'h3c
`define LEN_2 4'h2
`define LEN_4 4'h4
`define LEN_8 4'h8
`define HALF_STEP 2'h0
`define ADDR_CTRL 8'h00
`define ADDR_NODE 8'h04
`define ADDR_TAGS_A 8'h08
`define ADDR_TAGS_B 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_COUNT 8'h14
`define RST_STEP 2'h0
`define RST_VARIANT 1'h0
`define RST_NODE 7'h00
`define RST_TAG5 5'h00
`define RST_TAG4 4'h0
`define RST_POS 16'h0000
`define RES_NONE 3'h0
`define RES_OK 3'h1
`define RES_BAD 3'h2
`define RES_NOADDR 3'h3
`define RES_BLOCKED 3'h4
`define RES_MODE 3'h5
`endif

// ==== hw/frame_collect.v ====
/*
 Collects one bus frame byte by byte: identifier, data bytes, checksum.
 Checks identifier parity and classic checksum at frame end.
 Assumes a byte source on the same clock that marks frame start and end.
*/
`timescale 1ns/100ps
`default_nettype none
`include "position_command_decoder_consts.vh"
module frame_collect (
   input wire clk, // System clock
   input wire nrst, // Asynchronous reset, active low
   input wire ce, // Clock enable
   input wire rx_sof, // Frame start pulse
   input wire rx_valid, // Byte strobe
   input wire [7:0] rx_byte, // Received byte
   input wire rx_eof, // Frame end pulse
   output reg frame_ok, // Good frame pulse
   output reg frame_bad, // Parity, checksum or data length failure pulse
   output reg [5:0] frame_id, // Identifier without parity
   output reg [3:0] frame_len, // Number of data bytes
   output reg [63:0] frame_data // Data byte n at bits 8n-1 down to 8n-8
);
   reg [3:0] cnt;
   reg [7:0] raw_id;
   reg [7:0] acc;
   reg [7:0] prev;
   reg [7:0] last;
   reg [3:0] dlen;
   reg len_ok;

   // Parity bits over the six low identifier bits
   function [1:0] id_parity;
      input [5:0] i;
      begin
         id_parity = {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4]};
      end
   endfunction

   // Sum with carry wrapped back in
   function [7:0] add_carry;
      input [7:0] a;
      input [7:0] b;
      reg [8:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         add_carry = s[7:0] + {7'h00, s[8]};
      end
   endfunction

   // Data length check
   always @* begin
      dlen = cnt - 4'h2;
      len_ok = (dlen == `LEN_2) || (dlen == `LEN_4) || (dlen == `LEN_8);
   end

   // Byte collection and end-of-frame verdict
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 4'h0;
         raw_id <= 8'h00;
         acc <= 8'h00;
         prev <= 8'h00;
         last <= 8'h00;
         frame_ok <= 1'b0;
         frame_bad <= 1'b0;
         frame_id <= 6'h00;
         frame_len <= 4'h0;
         frame_data <= 64'h0;
      end else if (ce) begin
         frame_ok <= 1'b0;
         frame_bad <= 1'b0;
         if (rx_sof) begin
            cnt <= 4'h0;
            acc <= 8'h00;
            prev <= 8'h00;
         end else if (rx_valid) begin
            if (cnt != 4'hf)
               cnt <= cnt + 4'h1;
            if (cnt == 4'h0) begin
               raw_id <= rx_byte;
            end else begin
               prev <= acc;
               acc <= add_carry(acc, rx_byte);
               last <= rx_byte;
               if (cnt <= 4'h8)
                  frame_data[{cnt[2:0] - 3'h1, 3'b000} +: 8] <= rx_byte;
            end
         end else if (rx_eof) begin
            frame_id <= raw_id[5:0];
            frame_len <= dlen;
            if (len_ok && (raw_id[7:6] == id_parity(raw_id[5:0]))
               && (~prev == last))
               frame_ok <= 1'b1;
            else
               frame_bad <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== hw/position_command_decoder.v ====
/*
 Decodes full-range and compact absolute position frames and loads the
 target position for the motion logic. Holds a small register file.
 Assumes a byte source, priority and dual-positioning flags on clk;
 strap pins come from outside and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "position_command_decoder_consts.vh"
module position_command_decoder (
   input wire clk, // System clock, 125 MHz
   input wire nrst, // Asynchronous reset, active low
   input wire ce, // Clock enable, freezes all state when low
   input wire rx_sof, // Frame start pulse
   input wire rx_valid, // Received byte strobe
   input wire [7:0] rx_byte, // Received byte
   input wire rx_eof, // Frame end pulse
   input wire cmd_block, // Priority conditions forbid positioning
   input wire dual_busy, // Dual positioning sequence running
   input wire strap_pin_0, // Hardware address strap 0
   input wire strap_pin_1, // Hardware address strap 1
   input wire strap_pin_2, // Hardware address strap 2
   input wire [7:0] reg_addr, // Register byte address
   input wire [31:0] reg_wdata, // Register write data
   input wire reg_wr, // Register write strobe
   input wire reg_rd, // Register read strobe
   output reg [31:0] reg_rdata, // Read data, valid the cycle after reg_rd
   output reg [15:0] target_pos, // Target absolute position
   output reg move_strobe, // One-cycle pulse on a new target
   output reg [2:0] last_result // Verdict on the last frame
);
   wire frame_ok;
   wire frame_bad;
   wire [5:0] frame_id;
   wire [3:0] frame_len;
   wire [63:0] frame_data;

   reg [1:0] microstep_resolution;
   reg short_addressing_variant;
   reg [6:0] otp_node_number;
   reg [4:0] tag_direct;
   reg [4:0] tag_short2;
   reg [3:0] tag_gp4;
   reg [3:0] tag_short4;
   reg [3:0] tag_short8;
   reg [15:0] accept_count;
   reg [15:0] reject_count;
   reg [2:0] strap_meta;
   reg [2:0] strap_sync;

   reg [15:0] next_pos;
   reg [2:0] next_result;
   reg next_hit;
   reg found;
   reg compact;
   reg [2:0] nslot;
   reg [7:0] hb;
   reg [7:0] lb;
   reg [7:0] sb;
   integer k;

   // Frame assembly and integrity checks
   frame_collect u_collect (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .rx_sof(rx_sof),
      .rx_valid(rx_valid),
      .rx_byte(rx_byte),
      .rx_eof(rx_eof),
      .frame_ok(frame_ok),
      .frame_bad(frame_bad),
      .frame_id(frame_id),
      .frame_len(frame_len),
      .frame_data(frame_data)
   );

   // Data byte n of the current frame, counted from one
   function [7:0] dbyte;
      input integer n;
      begin
         dbyte = frame_data[8 * (n - 1) +: 8];
      end
   endfunction

   // Five-bit tagged identifier with identifier bit 5 clear
   function tag5_hit;
      input [5:0] id;
      input [4:0] tag;
      begin
         tag5_hit = !id[5] && (id[4:0] == tag);
      end
   endfunction

   // Four-bit tagged identifier with its two class bits on top
   function tag4_hit;
      input [5:0] id;
      input [1:0] cls;
      input [3:0] tag;
      begin
         tag4_hit = (id[5:4] == cls) && (id[3:0] == tag);
      end
   endfunction

   // Full seven-bit node match or broadcast
   function full_match;
      input [7:0] b;
      input [6:0] node;
      begin
         full_match = !b[7] || (b[6:0] == node);
      end
   endfunction

   // Four-bit compact address match
   function short_match;
      input [3:0] a;
      input variant;
      input [6:0] node;
      input strap2;
      begin
         if (variant)
            short_match = (a[2:0] == node[2:0]) && (a[3] == strap2);
         else
            short_match = (a == node[3:0]);
      end
   endfunction

   // Compact slot acceptance: a single slot reads bit 4 as broadcast, active
   // low; in multi-slot frames bit 4 must be set and the address must match
   function slot_hit;
      input [7:0] b;
      input single;
      input variant;
      input [6:0] node;
      input strap2;
      begin
         if (single && !b[4])
            slot_hit = 1'b1;
         else if (!b[4])
            slot_hit = 1'b0;
         else
            slot_hit = short_match(b[3:0], variant, node, strap2);
      end
   endfunction

   // High byte of a compact setpoint, sign copied up from setpoint bit 10
   function [7:0] sext_high;
      input [2:0] top;
      begin
         sext_high = {{5{top[2]}}, top};
      end
   endfunction

   // Counter step, wraps at the top
   function [15:0] count_up;
      input [15:0] c;
      begin
         count_up = c + 16'h0001;
      end
   endfunction

   // Two-flop synchronisers for the strap pins
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_meta <= 3'h0;
         strap_sync <= 3'h0;
      end else if (ce) begin
         strap_meta <= {strap_pin_2, strap_pin_1, strap_pin_0};
         strap_sync <= strap_meta;
      end
   end

   // Frame decode: pick the setpoint addressed to this node
   always @* begin
      next_pos = target_pos;
      next_result = `RES_NONE;
      next_hit = 1'b0;
      found = 1'b0;
      compact = 1'b0;
      nslot = 3'h0;
      hb = 8'h00;
      lb = 8'h00;
      sb = 8'h00;
      if (frame_bad) begin
         next_result = `RES_BAD;
      end else if (frame_ok) begin
         next_result = `RES_NOADDR;
         if (frame_id == `ID_MASTER_REQ) begin
            // Two-motor full frame, first matching slot wins
            if (frame_len == `LEN_8 && dbyte(1) == `APP_PREFIX
               && dbyte(2) == `OPC_MOVE_ABS) begin
               for (k = 0; k < 2; k = k + 1) begin
                  if (!found && dbyte(3 + 3 * k) == {1'b1, otp_node_number}) begin
                     found = 1'b1;
                     hb = dbyte(4 + 3 * k);
                     lb = dbyte(5 + 3 * k);
                  end
               end
            end
         end else if (tag4_hit(frame_id, 2'b10, tag_gp4)
            && frame_len == `LEN_4 && dbyte(1) == `OPC_MOVE_ABS) begin
            if (full_match(dbyte(2), otp_node_number)) begin
               found = 1'b1;
               hb = dbyte(3);
               lb = dbyte(4);
            end
         end else if (tag5_hit(frame_id, tag_direct) && frame_len == `LEN_2) begin
            found = 1'b1;
            hb = dbyte(1);
            lb = dbyte(2);
         end else begin
            compact = 1'b1;
            if (tag5_hit(frame_id, tag_short2) && frame_len == `LEN_2)
               nslot = 3'h1;
            else if (tag4_hit(frame_id, 2'b10, tag_short4) && frame_len == `LEN_4)
               nslot = 3'h2;
            else if (tag4_hit(frame_id, 2'b11, tag_short8) && frame_len == `LEN_8)
               nslot = 3'h4;
            else
               next_result = `RES_NONE;
            // First slot addressed to this node wins
            for (k = 0; k < 4; k = k + 1) begin
               sb = dbyte(1 + 2 * k);
               if (!found && k < nslot && slot_hit(sb, nslot == 3'h1,
                  short_addressing_variant, otp_node_number, strap_sync[2])) begin
                  found = 1'b1;
                  hb = sext_high(sb[7:5]);
                  lb = dbyte(2 + 2 * k);
               end
            end
         end
         if (found) begin
            if (compact && microstep_resolution != `HALF_STEP)
               next_result = `RES_MODE;
            else if (cmd_block || dual_busy)
               next_result = `RES_BLOCKED;
            else begin
               next_result = `RES_OK;
               next_pos = {hb, lb};
               next_hit = 1'b1;
            end
         end
      end
   end

   // Target register, strobe and verdict
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         target_pos <= `RST_POS;
         move_strobe <= 1'b0;
         last_result <= `RES_NONE;
      end else if (ce) begin
         move_strobe <= next_hit;
         target_pos <= next_pos;
         if (frame_ok || frame_bad)
            last_result <= next_result;
      end
   end

   // Accepted and refused command counters; unaddressed frames count nowhere
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         accept_count <= 16'h0000;
         reject_count <= 16'h0000;
      end else if (ce) begin
         if (next_hit)
            accept_count <= count_up(accept_count);
         else if (next_result == `RES_BAD || next_result == `RES_BLOCKED
            || next_result == `RES_MODE)
            reject_count <= count_up(reject_count);
      end
   end

   // Register writes
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         microstep_resolution <= `RST_STEP;
         short_addressing_variant <= `RST_VARIANT;
         otp_node_number <= `RST_NODE;
         tag_direct <= `RST_TAG5;
         tag_short2 <= `RST_TAG5;
         tag_gp4 <= `RST_TAG4;
         tag_short4 <= `RST_TAG4;
         tag_short8 <= `RST_TAG4;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            `ADDR_CTRL: begin
               microstep_resolution <= reg_wdata[1:0];
               short_addressing_variant <= reg_wdata[2];
            end
            `ADDR_NODE: begin
               otp_node_number <= reg_wdata[6:0];
            end
            `ADDR_TAGS_A: begin
               tag_direct <= reg_wdata[4:0];
               tag_short2 <= reg_wdata[12:8];
            end
            `ADDR_TAGS_B: begin
               tag_gp4 <= reg_wdata[3:0];
               tag_short4 <= reg_wdata[11:8];
               tag_short8 <= reg_wdata[19:16];
            end
            default: begin
            end
         endcase
      end
   end

   // Register reads, data stand only in the cycle after the strobe
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h00000000;
      end else if (ce) begin
         reg_rdata <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               `ADDR_CTRL: reg_rdata <= {29'h0, short_addressing_variant,
                  microstep_resolution};
               `ADDR_NODE: reg_rdata <= {25'h0, otp_node_number};
               `ADDR_TAGS_A: reg_rdata <= {19'h0, tag_short2, 3'h0, tag_direct};
               `ADDR_TAGS_B: reg_rdata <= {12'h0, tag_short8, 4'h0, tag_short4,
                  4'h0, tag_gp4};
               `ADDR_STATUS: reg_rdata <= {9'h0, strap_sync, dual_busy, last_result,
                  target_pos};
               `ADDR_COUNT: reg_rdata <= {reject_count, accept_count};
               default: reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/position_command_decoder_chk.sv ====
/* Checker for the position command decoder: verdict timing, strobe and reads.
   Assumes it is bound to the decoder's top module by port name. */
`timescale 1ns/100ps
`default_nettype none
module position_command_decoder_chk (
   input wire clk, // Clock
   input wire nrst, // Reset, active low
   input wire rx_eof, // Frame end pulse
   input wire cmd_block, // Priority block
   input wire dual_busy, // Dual positioning running
   input wire [7:0] reg_addr, // Register address
   input wire reg_rd, // Read strobe
   input wire [31:0] reg_rdata, // Read data
   input wire [15:0] target_pos, // Target position
   input wire move_strobe, // New target pulse
   input wire [2:0] last_result // Frame verdict
);
   // All checks on the one clock, quiet in reset
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   chk_strobe_single: assert property (move_strobe |=> !move_strobe)
      else $error("move strobe wider than one cycle");
   chk_strobe_timing: assert property (move_strobe |-> $past(rx_eof, 2))
      else $error("move strobe not two edges after frame end");
   chk_verdict_timing: assert property (!$stable(last_result) |-> $past(rx_eof, 2))
      else $error("verdict changed away from frame end");
   chk_target_pulse: assert property (!$stable(target_pos) |-> move_strobe)
      else $error("target moved without strobe");
   chk_accept_code: assert property (move_strobe |-> last_result == 3'h1)
      else $error("strobe without accepted verdict");
   chk_block_quiet: assert property (move_strobe |->
      !$past(cmd_block, 1) && !$past(dual_busy, 1))
      else $error("strobe while positioning blocked");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   chk_status_read: assert property ((reg_rd && reg_addr == 8'h10) |=>
      reg_rdata[18:0] == {$past(last_result), $past(target_pos)})
      else $error("status read differs from outputs");
   chk_unmapped_read: assert property ((reg_rd && reg_addr >= 8'h18) |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind position_command_decoder position_command_decoder_chk chk_i (.clk(clk), .nrst(nrst),
   .rx_eof(rx_eof), .cmd_block(cmd_block), .dual_busy(dual_busy), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .target_pos(target_pos),
   .move_strobe(move_strobe), .last_result(last_result));
`default_nettype wire

// ==== verif/lin_master_model.sv ====
/* Frame source in the bus master's place: protected identifier, data, checksum.
   Assumes the decoder's clock; tasks are called by the testbench. */
`timescale 1ns/100ps
`default_nettype none
module lin_master_model (
   input wire logic clk, // Clock
   output var logic rx_sof, // Frame start pulse
   output var logic rx_valid, // Byte strobe
   output var logic [7:0] rx_byte, // Byte on the link
   output var logic rx_eof // Frame end pulse
);
   // Link idle at time zero
   initial begin
      rx_sof = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      rx_eof = 1'b0;
   end
   // One byte per edge, strobe held between bytes
   task automatic put(input logic [7:0] b);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_byte <= b;
   endtask
   // Frame of n data bytes, first byte highest in d; bad spoils parity or checksum
   task automatic send(input logic [5:0] id, input int n, input logic [63:0] d,
         input logic [1:0] bad);
      logic [8:0] s;
      logic [7:0] pid;
      begin
         pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
         pid[7] = pid[7] ^ bad[0];
         s = 9'h000;
         @(posedge clk);
         rx_sof <= 1'b1;
         @(posedge clk);
         rx_sof <= 1'b0;
         rx_valid <= 1'b1;
         rx_byte <= pid;
         for (int i = 0; i < n; i++) begin
            put(d[8 * (n - 1 - i) +: 8]);
            s = s + d[8 * (n - 1 - i) +: 8];
            s = s[7:0] + s[8];
         end
         put(~s[7:0] ^ {7'h00, bad[1]});
         @(posedge clk);
         rx_valid <= 1'b0;
         rx_byte <= ~rx_byte;
         rx_eof <= 1'b1;
         @(posedge clk);
         rx_eof <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ==== verif/position_command_decoder_tb.sv ====
/* Testbench of the position command decoder: register tasks, frame scenarios.
   Assumes the bus master model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module position_command_decoder_tb;
   logic clk, nrst, cmd_block, dual_busy, strap_pin_2, reg_wr, reg_rd;
   logic rx_sof, rx_valid, rx_eof, move_strobe;
   logic [7:0] reg_addr, rx_byte;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] target_pos;
   logic [2:0] last_result;
   int failures = 0;
   int n_compared = 0;
   lin_master_model m (.clk(clk), .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_eof(rx_eof));
   position_command_decoder dut (.clk(clk), .nrst(nrst), .ce(1'b1), .rx_sof(rx_sof),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eof(rx_eof), .cmd_block(cmd_block),
      .dual_busy(dual_busy), .strap_pin_0(1'b1), .strap_pin_1(1'b1), .strap_pin_2(strap_pin_2),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .target_pos(target_pos), .move_strobe(move_strobe),
      .last_result(last_result));
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic final_report;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_move(input logic [15:0] pos, input logic [2:0] res, input logic stb);
      n_compared++;
      if ({target_pos, last_result, move_strobe} !== {pos, res, stb}) begin
         failures++;
         $display("CHECK FAILED at %0t: frame gave %h %h %b", $time, target_pos, last_result,
            move_strobe);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      cmp_reg(reg_rdata, exp);
   endtask
   // Send a frame, then look at the outputs in the cycle after the edge past its end
   task automatic fr(input logic [5:0] id, input int n, input logic [63:0] d,
         input logic [1:0] bad, input logic [15:0] pos, input logic [2:0] res, input logic stb);
      m.send(id, n, d, bad);
      @(posedge clk);
      #1;
      cmp_move(pos, res, stb);
   endtask
   // Hang guard, far beyond the expected run of about two hundred cycles
   initial begin
      #100000;
      failures++;
      final_report();
   end
   // Main sequence
   initial begin
      nrst = 1'b0;
      {cmd_block, dual_busy, reg_wr, reg_rd} = 4'h0;
      strap_pin_2 = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h14, 32'h0);
      wr(8'h20, 32'hffffffff);
      rd(8'h20, 32'h0);
      wr(8'h04, 32'h5);
      wr(8'h08, 32'h0201);
      wr(8'h0c, 32'h050403);
      rd(8'h04, 32'h5);
      rd(8'h0c, 32'h050403);
      $display("registers test done");
      fr(6'h01, 2, 64'h8001, 2'b00, 16'h8001, 3'h1, 1'b1);
      fr(6'h23, 4, 64'h8b851234, 2'b00, 16'h1234, 3'h1, 1'b1);
      fr(6'h23, 4, 64'h8b865555, 2'b00, 16'h1234, 3'h3, 1'b0);
      fr(6'h23, 4, 64'h8b06007f, 2'b00, 16'h007f, 3'h1, 1'b1);
      fr(6'h3c, 8, 64'h808b86111185fedc, 2'b00, 16'hfedc, 3'h1, 1'b1);
      $display("full range test done");
      fr(6'h02, 2, 64'h95ab, 2'b00, 16'hfcab, 3'h1, 1'b1);
      fr(6'h02, 2, 64'h0312, 2'b00, 16'h0012, 3'h1, 1'b1);
      fr(6'h02, 2, 64'h1600, 2'b00, 16'h0012, 3'h3, 1'b0);
      fr(6'h24, 4, 64'h170075ff, 2'b00, 16'h03ff, 3'h1, 1'b1);
      fr(6'h24, 4, 64'h05aa05bb, 2'b00, 16'h03ff, 3'h3, 1'b0);
      fr(6'h35, 8, 64'h17001800f5011900, 2'b00, 16'hff01, 3'h1, 1'b1);
      $display("compact test done");
      fr(6'h01, 2, 64'h0005, 2'b10, 16'hff01, 3'h2, 1'b0);
      fr(6'h01, 2, 64'h0005, 2'b01, 16'hff01, 3'h2, 1'b0);
      wr(8'h00, 32'h1);
      fr(6'h02, 2, 64'h95ab, 2'b00, 16'hff01, 3'h5, 1'b0);
      wr(8'h00, 32'h0);
      cmd_block <= 1'b1;
      fr(6'h01, 2, 64'h0005, 2'b00, 16'hff01, 3'h4, 1'b0);
      cmd_block <= 1'b0;
      dual_busy <= 1'b1;
      fr(6'h01, 2, 64'h0005, 2'b00, 16'hff01, 3'h4, 1'b0);
      dual_busy <= 1'b0;
      $display("refusal test done");
      wr(8'h00, 32'h4);
      fr(6'h02, 2, 64'h1d20, 2'b00, 16'h0020, 3'h1, 1'b1);
      strap_pin_2 <= 1'b0;
      fr(6'h02, 2, 64'h1d20, 2'b00, 16'h0020, 3'h3, 1'b0);
      rd(8'h10, 32'h00330020);
      rd(8'h14, 32'h00050009);
      $display("address variant test done");
      final_report();
   end
endmodule
`default_nettype wire
